// file: src/nfc_timer_pkg.sv
// Package: register map, field layout and step counts of the timer block
package nfc_timer_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam logic [5:0] ADDR_TIMER_CTRL = 6'h11;
	localparam logic [5:0] ADDR_GP_HIGH = 6'h12;
	localparam logic [5:0] ADDR_GP_LOW = 6'h13;
	localparam logic [5:0] ADDR_MASK_MAIN = 6'h14;
	localparam logic [5:0] ADDR_MASK_TIMER = 6'h15;
	localparam logic [5:0] ADDR_MASK_ERR = 6'h16;
	localparam logic [5:0] ADDR_STAT_MAIN = 6'h17;
	localparam logic [5:0] ADDR_STAT_TIMER = 6'h18;
	localparam logic [5:0] ADDR_STAT_ERR = 6'h19;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] GP_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int TRIG_MSB = 7;
	localparam int TRIG_LSB = 5;
	localparam int NRT_EMV_BIT = 1;
	localparam int NRT_STEP_BIT = 0;
	localparam int MAIN_EVT_LSB = 2;
	localparam int MAIN_TIMER_BIT = 1;
	localparam int MAIN_ERR_BIT = 0;
	localparam int GPE_BIT = 5;

	// ----------------------------------------------------------------
	// Trigger source encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] TRIG_NONE = 3'h0;
	localparam logic [2:0] TRIG_RX_END = 3'h1;
	localparam logic [2:0] TRIG_RX_START = 3'h2;
	localparam logic [2:0] TRIG_TX_END_NFC = 3'h3;

	// ----------------------------------------------------------------
	// Step lengths in carrier periods and no-response counter width
	// ----------------------------------------------------------------
	localparam int GP_STEP_FC = 8;
	localparam int NRT_FINE_FC = 64;
	localparam int NRT_COARSE_FC = 4096;
	localparam int NRT_CNT_W = 12;

endpackage : nfc_timer_pkg

// file: src/gp_step_timer.sv
// General purpose down counter with a carrier-period prescaler
`timescale 1ns/1ps
module gp_step_timer #(
	parameter int CNT_W = 16,
	parameter int STEP_FC = nfc_timer_pkg::GP_STEP_FC
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic fc_en_i,
	input wire logic start_i,
	input wire logic [CNT_W-1:0] load_i,
	output logic running_o,
	output logic expire_o
);

	localparam int PRE_W = $clog2(STEP_FC);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_FC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	typedef enum logic {IDLE, RUN} tstate_t;

	tstate_t state_q;
	logic [PRE_W-1:0] pre_q;
	logic [CNT_W-1:0] cnt_q;
	logic step_end;

	assign step_end = fc_en_i && (pre_q == PRE_LAST);
	assign running_o = (state_q == RUN);

	// Restart reloads even while running; a zero load lasts one step
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= IDLE;
			pre_q <= '0;
			cnt_q <= '0;
			expire_o <= 1'b0;
		end else if (ce_i) begin
			expire_o <= 1'b0;
			case (state_q)
				IDLE: begin
					if (start_i) begin
						state_q <= RUN;
						pre_q <= '0;
						cnt_q <= load_i;
					end
				end
				RUN: begin
					if (start_i) begin
						pre_q <= '0;
						cnt_q <= load_i;
					end else if (fc_en_i) begin
						pre_q <= step_end ? '0 : pre_q + 1'b1;
						if (step_end) begin
							if (cnt_q <= CNT_ONE) begin
								state_q <= IDLE;
								expire_o <= 1'b1;
							end else begin
								cnt_q <= cnt_q - CNT_ONE;
							end
						end
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end

endmodule : gp_step_timer

// file: src/timer_trigger_irq_regs.sv
// Timer control, timer trigger, interrupt masks and interrupt status block
`timescale 1ns/1ps
module timer_trigger_irq_regs (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic fc_en_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic set_default_i,
	input wire logic gp_start_cmd_i,
	input wire logic rx_start_i,
	input wire logic rx_end_i,
	input wire logic tx_end_i,
	input wire logic nfc_mode_i,
	input wire logic [5:0] main_evt_i,
	input wire logic [7:0] timer_evt_i,
	input wire logic [7:0] err_evt_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_o,
	output logic field_off_o,
	output logic nrt_emv_o,
	output logic nrt_step_o,
	output logic nrt_tick_o,
	output logic gp_running_o
);

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] gp_high_q;
	logic [7:0] gp_low_q;
	logic [7:0] mask_main_q;
	logic [7:0] mask_timer_q;
	logic [7:0] mask_err_q;
	logic [5:0] main_evt_q;
	logic main_tim_q;
	logic main_err_q;
	logic [7:0] timer_st_q;
	logic [7:0] err_st_q;
	logic [7:0] main_stat;
	logic [7:0] timer_set;
	logic [2:0] trig_sel;
	logic rd_main;
	logic rd_timer;
	logic rd_err;
	logic trig_hit;
	logic tx_trig;
	logic gp_start;
	logic gp_expire;
	logic gp_running;
	logic armed_q;
	logic [nfc_timer_pkg::NRT_CNT_W-1:0] nrt_cnt_q;
	logic [nfc_timer_pkg::NRT_CNT_W-1:0] nrt_last;

	assign trig_sel = ctrl_q[nfc_timer_pkg::TRIG_MSB:nfc_timer_pkg::TRIG_LSB];
	assign rd_main = reg_rd_i && (reg_addr_i == nfc_timer_pkg::ADDR_STAT_MAIN);
	assign rd_timer = reg_rd_i && (reg_addr_i == nfc_timer_pkg::ADDR_STAT_TIMER);
	assign rd_err = reg_rd_i && (reg_addr_i == nfc_timer_pkg::ADDR_STAT_ERR);
	assign main_stat = {main_evt_q, main_tim_q, main_err_q};

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= nfc_timer_pkg::CTRL_RESET;
			mask_main_q <= nfc_timer_pkg::MASK_RESET;
			mask_timer_q <= nfc_timer_pkg::MASK_RESET;
			mask_err_q <= nfc_timer_pkg::MASK_RESET;
		end else if (ce_i) begin
			if (set_default_i) begin
				ctrl_q <= nfc_timer_pkg::CTRL_RESET;
				mask_main_q <= nfc_timer_pkg::MASK_RESET;
				mask_timer_q <= nfc_timer_pkg::MASK_RESET;
				mask_err_q <= nfc_timer_pkg::MASK_RESET;
			end else if (reg_wr_i) begin
				case (reg_addr_i)
					nfc_timer_pkg::ADDR_TIMER_CTRL: ctrl_q <= reg_wdata_i;
					nfc_timer_pkg::ADDR_MASK_MAIN: mask_main_q <= reg_wdata_i;
					nfc_timer_pkg::ADDR_MASK_TIMER: mask_timer_q <= reg_wdata_i;
					nfc_timer_pkg::ADDR_MASK_ERR: mask_err_q <= reg_wdata_i;
					default: ;
				endcase
			end
		end
	end

	// No documented default: left untouched by set-default
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gp_high_q <= nfc_timer_pkg::GP_RESET;
			gp_low_q <= nfc_timer_pkg::GP_RESET;
		end else if (ce_i && reg_wr_i) begin
			if (reg_addr_i == nfc_timer_pkg::ADDR_GP_HIGH)
				gp_high_q <= reg_wdata_i;
			if (reg_addr_i == nfc_timer_pkg::ADDR_GP_LOW)
				gp_low_q <= reg_wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= nfc_timer_pkg::READ_ZERO;
		end else if (ce_i && reg_rd_i) begin
			case (reg_addr_i)
				nfc_timer_pkg::ADDR_TIMER_CTRL: reg_rdata_o <= ctrl_q;
				nfc_timer_pkg::ADDR_GP_HIGH: reg_rdata_o <= gp_high_q;
				nfc_timer_pkg::ADDR_GP_LOW: reg_rdata_o <= gp_low_q;
				nfc_timer_pkg::ADDR_MASK_MAIN: reg_rdata_o <= mask_main_q;
				nfc_timer_pkg::ADDR_MASK_TIMER: reg_rdata_o <= mask_timer_q;
				nfc_timer_pkg::ADDR_MASK_ERR: reg_rdata_o <= mask_err_q;
				nfc_timer_pkg::ADDR_STAT_MAIN: reg_rdata_o <= main_stat;
				nfc_timer_pkg::ADDR_STAT_TIMER: reg_rdata_o <= timer_st_q;
				nfc_timer_pkg::ADDR_STAT_ERR: reg_rdata_o <= err_st_q;
				default: reg_rdata_o <= nfc_timer_pkg::READ_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// General purpose timer and its trigger
	// ----------------------------------------------------------------
	assign tx_trig = (trig_sel == nfc_timer_pkg::TRIG_TX_END_NFC) &&
		tx_end_i && nfc_mode_i;
	always_comb begin
		case (trig_sel)
			nfc_timer_pkg::TRIG_RX_END: trig_hit = rx_end_i;
			nfc_timer_pkg::TRIG_RX_START: trig_hit = rx_start_i;
			nfc_timer_pkg::TRIG_TX_END_NFC: trig_hit = tx_trig;
			default: trig_hit = 1'b0;
		endcase
	end
	assign gp_start = gp_start_cmd_i || trig_hit;

	gp_step_timer #(
		.CNT_W(16),
		.STEP_FC(nfc_timer_pkg::GP_STEP_FC)
	) u_gp_timer (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.fc_en_i(fc_en_i),
		.start_i(gp_start),
		.load_i({gp_high_q, gp_low_q}),
		.running_o(gp_running),
		.expire_o(gp_expire)
	);

	// Field drop only when this run came from the NFC transmit trigger
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			armed_q <= 1'b0;
			field_off_o <= 1'b0;
			gp_running_o <= 1'b0;
		end else if (ce_i) begin
			if (gp_start)
				armed_q <= tx_trig;
			else if (gp_expire)
				armed_q <= 1'b0;
			field_off_o <= gp_expire && armed_q;
			gp_running_o <= gp_running;
		end
	end

	// ----------------------------------------------------------------
	// No-response timer step and mode
	// ----------------------------------------------------------------
	assign nrt_last = ctrl_q[nfc_timer_pkg::NRT_STEP_BIT] ?
		nfc_timer_pkg::NRT_CNT_W'(nfc_timer_pkg::NRT_COARSE_FC - 1) :
		nfc_timer_pkg::NRT_CNT_W'(nfc_timer_pkg::NRT_FINE_FC - 1);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nrt_cnt_q <= '0;
			nrt_tick_o <= 1'b0;
			nrt_step_o <= 1'b0;
			nrt_emv_o <= 1'b0;
		end else if (ce_i) begin
			nrt_step_o <= ctrl_q[nfc_timer_pkg::NRT_STEP_BIT];
			nrt_emv_o <= ctrl_q[nfc_timer_pkg::NRT_EMV_BIT];
			nrt_tick_o <= fc_en_i && (nrt_cnt_q >= nrt_last);
			if (fc_en_i)
				nrt_cnt_q <= (nrt_cnt_q >= nrt_last) ? '0 : nrt_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status; a new event wins over the read clear
	// ----------------------------------------------------------------
	always_comb begin
		timer_set = timer_evt_i;
		timer_set[nfc_timer_pkg::GPE_BIT] = gp_expire;
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_evt_q <= '0;
			main_tim_q <= 1'b0;
			main_err_q <= 1'b0;
			timer_st_q <= nfc_timer_pkg::STAT_RESET;
			err_st_q <= nfc_timer_pkg::STAT_RESET;
		end else if (ce_i) begin
			if (set_default_i) begin
				main_evt_q <= '0;
				main_tim_q <= 1'b0;
				main_err_q <= 1'b0;
				timer_st_q <= nfc_timer_pkg::STAT_RESET;
				err_st_q <= nfc_timer_pkg::STAT_RESET;
			end else begin
				main_evt_q <= (rd_main ? '0 : main_evt_q) | main_evt_i;
				main_tim_q <= (!rd_timer && main_tim_q) || (|timer_set);
				main_err_q <= (!rd_err && main_err_q) || (|err_evt_i);
				timer_st_q <= (rd_main ? nfc_timer_pkg::STAT_RESET :
					timer_st_q) | timer_set;
				err_st_q <= (rd_err ? nfc_timer_pkg::STAT_RESET :
					err_st_q) | err_evt_i;
			end
		end
	end

	// Unused main mask bits 1..0 never gate anything
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= (|(main_evt_q & ~mask_main_q[7:nfc_timer_pkg::MAIN_EVT_LSB]))
				|| (|(timer_st_q & ~mask_timer_q))
				|| (|(err_st_q & ~mask_err_q));
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_tx_trigger;
		ce_i && !gp_start_cmd_i && tx_trig;
	endsequence
	sequence s_armed_expiry;
		ce_i && gp_expire && armed_q;
	endsequence

	a_default_zeroes: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && set_default_i |=> ctrl_q == 8'h00 && mask_main_q == 8'h00
		&& mask_timer_q == 8'h00 && mask_err_q == 8'h00)
		else $error("Set default left control or masks nonzero");
	a_rx_end_start: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && trig_sel == 3'h1 && rx_end_i |=> gp_running)
		else $error("End of receive did not start the timer");
	a_no_trigger: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && trig_sel == 3'h0 && !gp_start_cmd_i && !gp_running |=> !gp_running)
		else $error("Timer started without trigger or command");
	a_tx_field_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_tx_trigger |=> armed_q)
		else $error("Transmit trigger did not arm the field drop");
	a_field_drop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_armed_expiry |=> field_off_o)
		else $error("Field not dropped on armed expiry");
	a_gpe_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && gp_expire && !set_default_i |=> timer_st_q[5] && main_tim_q)
		else $error("Timer expiry flag not set");
	a_main_read_clr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && rd_main && main_evt_i == 6'h00 |=> main_evt_q == 6'h00)
		else $error("Main status not cleared by read");
	a_timer_clr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && rd_main && !set_default_i |=> timer_st_q == $past(timer_set))
		else $error("Timer status not cleared after main read");
	a_irq_unmasked: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && (|(timer_st_q & ~mask_timer_q)) |=> irq_o)
		else $error("Unmasked flag did not raise the interrupt");
	a_irq_quiet: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && main_evt_q == 6'h00 && timer_st_q == 8'h00
		&& err_st_q == 8'h00 |=> !irq_o)
		else $error("Interrupt raised with no flag set");
	a_emv_mode: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i |=> nrt_emv_o == $past(ctrl_q[1]))
		else $error("EMV mode output does not follow control bit");

endmodule : timer_trigger_irq_regs

// file: bench/mcu_host_model.sv
// Host model: register strobe master, drives at falling edge
`timescale 1ns/1ps
module mcu_host_model (
	input wire logic mclk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [5:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 6'h3f;
		reg_wdata_o = 8'h00;
	end

	// Idle bus shows inverted values so stale data never looks valid
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [7:0] v);
		@(negedge mclk_i);
		reg_wr_o = w;
		reg_rd_o = !w;
		reg_addr_o = a;
		reg_wdata_o = v;
		@(negedge mclk_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~v;
	endtask : acc

	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		acc(1'b1, a, v);
	endtask : wr

	// Data is taken a full cycle after the strobe is released
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		acc(1'b0, a, 8'h00);
		@(negedge mclk_i);
		v = reg_rdata_i;
	endtask : rd
endmodule : mcu_host_model

// file: bench/timer_trigger_irq_mask_regs_tb_top.sv
// Testbench top: register, trigger and interrupt scenarios
`timescale 1ns/1ps
module timer_trigger_irq_mask_regs_tb_top;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic fc_en_i = 1'b0;
	logic set_default_i = 1'b0;
	logic gp_start_cmd_i = 1'b0;
	logic rx_start_i = 1'b0;
	logic rx_end_i = 1'b0;
	logic tx_end_i = 1'b0;
	logic nfc_mode_i = 1'b1;
	logic [5:0] main_evt_i = 6'h00;
	logic [7:0] timer_evt_i = 8'h00;
	logic [7:0] err_evt_i = 8'h00;
	logic reg_wr_i, reg_rd_i, irq_o, field_off_o;
	logic nrt_emv_o, nrt_step_o, nrt_tick_o, gp_running_o;
	logic [5:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, d;
	int fails = 0;
	int checked = 0;
	int fc_cnt = 0;
	int tick_gap = 0;
	int foff = 0;

	always #5 mclk_i = ~mclk_i;
	// Carrier strobe every second cycle
	always @(negedge mclk_i) fc_en_i <= ~fc_en_i;
	always @(posedge mclk_i) begin
		foff <= foff + int'(field_off_o);
		if (nrt_tick_o === 1'b1) begin
			tick_gap <= fc_cnt + int'(fc_en_i);
			fc_cnt <= 0;
		end else begin
			fc_cnt <= fc_cnt + int'(fc_en_i);
		end
	end

	timer_trigger_irq_regs i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.ce_i(ce_i), .fc_en_i(fc_en_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .set_default_i(set_default_i),
		.gp_start_cmd_i(gp_start_cmd_i), .rx_start_i(rx_start_i),
		.rx_end_i(rx_end_i), .tx_end_i(tx_end_i),
		.nfc_mode_i(nfc_mode_i), .main_evt_i(main_evt_i),
		.timer_evt_i(timer_evt_i), .err_evt_i(err_evt_i),
		.reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
		.field_off_o(field_off_o), .nrt_emv_o(nrt_emv_o),
		.nrt_step_o(nrt_step_o), .nrt_tick_o(nrt_tick_o),
		.gp_running_o(gp_running_o));
	mcu_host_model i_host (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o),
		.reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

	task automatic chk(input string n, input logic [15:0] got,
		input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic rdchk(input string n, input logic [5:0] a,
		input logic [7:0] e);
		i_host.rd(a, d);
		chk(n, {8'h00, d}, {8'h00, e});
	endtask : rdchk
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : cyc
	// Bits: direct start, tx end, rx start, rx end
	task automatic pulse(input logic [3:0] m);
		cyc(1);
		{gp_start_cmd_i, tx_end_i, rx_start_i, rx_end_i} = m;
		cyc(1);
		{gp_start_cmd_i, tx_end_i, rx_start_i, rx_end_i} = 4'h0;
	endtask : pulse
	task automatic evts(input logic [7:0] mv, input logic [7:0] tv,
		input logic [7:0] ev);
		cyc(1);
		{main_evt_i, timer_evt_i, err_evt_i} = {mv[5:0], tv, ev};
		cyc(1);
		{main_evt_i, timer_evt_i, err_evt_i} = 22'h0;
	endtask : evts
	task automatic set_def;
		cyc(1);
		set_default_i = 1'b1;
		cyc(1);
		set_default_i = 1'b0;
	endtask : set_def
	task automatic wait_tick;
		int i;
		i = 0;
		cyc(1);
		while (nrt_tick_o !== 1'b1 && i < 10000) begin
			cyc(1);
			i++;
		end
		chk("tick", 16'(i < 10000), 16'h1);
	endtask : wait_tick
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		#600000;
		fails++;
		$display("mismatch watchdog expected end seen timeout");
		stop_test();
	end

	initial begin
		logic [2:0] s;
		logic [3:0] m;
		logic go;
		int f0;
		logic [7:0] v[6];
		v = '{8'h43, 8'ha5, 8'ha5, 8'hfc, 8'ha5, 8'ha5};
		cyc(20);
		nrst_i = 1'b1;
		// ----
		// Registers
		// ----
		for (int k = 0; k < 6; k++) rdchk("rst", 6'h11 + 6'(k), 8'h00);
		for (int k = 0; k < 6; k++) i_host.wr(6'h11 + 6'(k), v[k]);
		for (int k = 0; k < 6; k++) rdchk("rw", 6'h11 + 6'(k), v[k]);
		chk("nrt", {nrt_emv_o, nrt_step_o}, 16'h3);
		ce_i = 1'b0;
		i_host.wr(6'h14, 8'h00);
		ce_i = 1'b1;
		rdchk("ce", 6'h14, 8'hfc);
		i_host.wr(6'h17, 8'hff);
		rdchk("ro", 6'h17, 8'h00);
		rdchk("unmapped", 6'h3f, 8'h00);
		set_def();
		for (int k = 0; k < 6; k++)
			rdchk("def", 6'h11 + 6'(k), (k == 1 || k == 2) ? 8'ha5 : 8'h00);
		chk("nrtdef", {nrt_emv_o, nrt_step_o}, 16'h0);
		$display("test registers done");
		// ----
		// No-response step
		// ----
		// First tick after a step change spans the old step; skip it
		repeat (3) wait_tick();
		chk("step64", 16'(tick_gap), 16'd64);
		i_host.wr(6'h11, 8'h01);
		repeat (3) wait_tick();
		chk("step4096", 16'(tick_gap), 16'd4096);
		$display("test step done");
		// ----
		// Trigger selection and timeout
		// ----
		i_host.wr(6'h12, 8'h00);
		i_host.wr(6'h13, 8'h02);
		for (int k = 0; k < 6; k++) begin
			s = (k == 5) ? 3'h3 : 3'(k);
			m = (s == 3'h0) ? 4'h8 : (s > 3'h3) ? 4'h0 : 4'h1 << (s - 3'h1);
			go = (m != 4'h0) && (k != 5);
			nfc_mode_i = (k != 5);
			f0 = foff;
			i_host.wr(6'h11, {s, 5'h00});
			pulse(~m & 4'h7);
			cyc(3);
			chk("idle", gp_running_o, 16'h0);
			pulse(m);
			cyc(28);
			chk("run", gp_running_o, {15'h0, go});
			cyc(10);
			chk("end", {irq_o, gp_running_o}, {14'h0, go, 1'b0});
			rdchk("gpe", 6'h18, go ? 8'h20 : 8'h00);
			rdchk("sum", 6'h17, 8'h00);
			chk("field", 16'(foff - f0), {15'h0, go && s == 3'h3});
		end
		// Restart before expiry must reload and expire once, later
		pulse(4'h8);
		cyc(20);
		pulse(4'h8);
		cyc(20);
		chk("restart", gp_running_o, 16'h1);
		cyc(20);
		chk("once", gp_running_o, 16'h0);
		rdchk("gpe1", 6'h18, 8'h20);
		rdchk("sum1", 6'h17, 8'h00);
		$display("test trigger done");
		// ----
		// Status and masks
		// ----
		evts(8'h3f, 8'h00, 8'h00);
		cyc(2);
		chk("irq", irq_o, 16'h1);
		rdchk("main", 6'h17, 8'hfc);
		rdchk("mclr", 6'h17, 8'h00);
		evts(8'h00, 8'hdf, 8'h00);
		rdchk("tsum", 6'h17, 8'h02);
		rdchk("tkeep", 6'h17, 8'h02);
		rdchk("tclr", 6'h18, 8'h00);
		rdchk("tgone", 6'h17, 8'h00);
		evts(8'h00, 8'h00, 8'hff);
		rdchk("esum", 6'h17, 8'h01);
		rdchk("err", 6'h19, 8'hff);
		rdchk("egone", 6'h17, 8'h00);
		cyc(2);
		chk("noirq", irq_o, 16'h0);
		for (int k = 0; k < 3; k++) i_host.wr(6'h14 + 6'(k), 8'hff);
		evts(8'h3f, 8'hdf, 8'hff);
		cyc(2);
		chk("masked", irq_o, 16'h0);
		for (int k = 0; k < 3; k++) begin
			i_host.wr(6'h14 + 6'(k), 8'h00);
			cyc(2);
			chk("unmask", irq_o, 16'h1);
			i_host.wr(6'h14 + 6'(k), 8'hff);
			cyc(2);
			chk("remask", irq_o, 16'h0);
		end
		set_def();
		cyc(2);
		chk("defirq", irq_o, 16'h0);
		$display("test status done");
		stop_test();
	end
endmodule : timer_trigger_irq_mask_regs_tb_top
